/* File: rtl/ext_bus_cfg_pkg.sv */
// Function
// - six 8-bit registers decode at lower addresses 0xfed0 through 0xfed5 in order.
// - area width register holds one bit per area, bit position equal to area number.
// - width bit 0 selects a 16-bit data bus, 1 selects an 8-bit data bus.
// - power-on loads width all ones in every mode; hardware standby loads all ones in modes 1-3, 5-7 and zeros in mode 4.
// - width and access-state registers hold their contents through manual reset and software standby.
// - on-chip memory and internal registers keep their fixed width regardless of width bits.
// - in normal mode only width bit 0 matters, for the whole external space.
// - access-state bit 0 gives two-state access, 1 gives three-state access.
// - the access-state bit also enables wait insertion when 1 and disables it when 0.
// - power-on or hardware standby loads the access-state register with all ones.
// - on-chip memory and internal registers keep their fixed state count regardless of state bits.
// - in normal mode only access-state bit 0 matters, for the whole external space.
// - power-on loads wait counts with 0xff, bus controls with 0xd0 and 0x3c, all kept on manual reset.
// - advanced mode splits external space into eight 2-Mbyte areas, normal mode uses one area.
// - program waits from the wait count field are inserted only when the area state bit is 1.
package ext_bus_cfg_pkg;
   localparam int          ADDR_W        = 16;
   localparam int          DATA_W        = 8;
   localparam int          AREA_N        = 8;
   localparam int          AREA_SHIFT    = 21;
   localparam logic [15:0] OFS_WIDTH     = 16'hfed0;
   localparam logic [15:0] OFS_STATES    = 16'hfed1;
   localparam logic [15:0] OFS_WAIT_UP   = 16'hfed2;
   localparam logic [15:0] OFS_WAIT_LO   = 16'hfed3;
   localparam logic [15:0] OFS_BCTL_UP   = 16'hfed4;
   localparam logic [15:0] OFS_BCTL_LO   = 16'hfed5;
   localparam logic [7:0]  RST_WIDTH_ON  = 8'hff;
   localparam logic [7:0]  RST_WIDTH_M4  = 8'h00;
   localparam logic [7:0]  RST_STATES    = 8'hff;
   localparam logic [7:0]  RST_WAIT      = 8'hff;
   localparam logic [7:0]  RST_BCTL_UP   = 8'hd0;
   localparam logic [7:0]  RST_BCTL_LO   = 8'h3c;
   localparam logic [2:0]  MODE_FOUR     = 3'h4;
   localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
endpackage : ext_bus_cfg_pkg

/* File: rtl/ext_bus_cfg_regs.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_cfg_regs (
   input  wire logic                                 clk_i,
   input  wire logic                                 resetn_i,
   input  wire logic                                 hw_standby_i,
   input  wire logic [2:0]                           op_mode_i,
   input  wire logic                                 normal_mode_i,
   input  wire logic [ext_bus_cfg_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic [ext_bus_cfg_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                                 reg_wr_i,
   input  wire logic                                 reg_rd_i,
   output logic      [ext_bus_cfg_pkg::DATA_W-1:0]   reg_rdata_o,
   input  wire logic                                 cycle_start_i,
   input  wire logic [23:0]                          cycle_addr_i,
   input  wire logic                                 cycle_internal_i,
   output logic                                      cycle_8bit_o,
   output logic                                      cycle_3state_o,
   output logic                                      cycle_wait_en_o,
   output logic      [1:0]                           cycle_wait_cnt_o,
   output logic      [7:0]                           bus_control_upper_o,
   output logic      [7:0]                           bus_control_lower_o
);
   import ext_bus_cfg_pkg::*;

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] area_bus_width_r;
   logic [7:0] area_access_states_r;
   logic [7:0] wait_count_upper_r;
   logic [7:0] wait_count_lower_r;
   logic [7:0] bus_control_upper_r;
   logic [7:0] bus_control_lower_r;
   logic       width_load_r;
   logic       mode_four_r;

   // strap mode after reset release, clocked so no port feeds async reset
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         width_load_r <= 1'b1;
         mode_four_r  <= 1'b0;
      end else begin
         width_load_r <= hw_standby_i;
         mode_four_r  <= (op_mode_i == MODE_FOUR);
      end
   end

   // manual reset does not touch it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         area_bus_width_r <= RST_WIDTH_ON;
      end else if (hw_standby_i) begin
         area_bus_width_r <= RST_WIDTH_ON;
      end else if (width_load_r) begin
         area_bus_width_r <= mode_four_r ? RST_WIDTH_M4 : RST_WIDTH_ON;
      end else if (reg_wr_i && reg_addr_i == OFS_WIDTH) begin
         area_bus_width_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         area_access_states_r <= RST_STATES;
      end else if (hw_standby_i) begin
         area_access_states_r <= RST_STATES;
      end else if (reg_wr_i && reg_addr_i == OFS_STATES) begin
         area_access_states_r <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_count_upper_r  <= RST_WAIT;
         wait_count_lower_r  <= RST_WAIT;
         bus_control_upper_r <= RST_BCTL_UP;
         bus_control_lower_r <= RST_BCTL_LO;
      end else if (hw_standby_i) begin
         wait_count_upper_r  <= RST_WAIT;
         wait_count_lower_r  <= RST_WAIT;
         bus_control_upper_r <= RST_BCTL_UP;
         bus_control_lower_r <= RST_BCTL_LO;
      end else if (reg_wr_i) begin
         if (reg_addr_i == OFS_WAIT_UP) begin
            wait_count_upper_r <= reg_wdata_i;
         end
         if (reg_addr_i == OFS_WAIT_LO) begin
            wait_count_lower_r <= reg_wdata_i;
         end
         if (reg_addr_i == OFS_BCTL_UP) begin
            bus_control_upper_r <= reg_wdata_i;
         end
         if (reg_addr_i == OFS_BCTL_LO) begin
            bus_control_lower_r <= reg_wdata_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // read decode
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= RD_UNMAPPED;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_WIDTH:   reg_rdata_o <= area_bus_width_r;
            OFS_STATES:  reg_rdata_o <= area_access_states_r;
            OFS_WAIT_UP: reg_rdata_o <= wait_count_upper_r;
            OFS_WAIT_LO: reg_rdata_o <= wait_count_lower_r;
            OFS_BCTL_UP: reg_rdata_o <= bus_control_upper_r;
            OFS_BCTL_LO: reg_rdata_o <= bus_control_lower_r;
            default:     reg_rdata_o <= RD_UNMAPPED;
         endcase
      end else begin
         reg_rdata_o <= RD_UNMAPPED;
      end
   end

   // ----------------------------------------------------------------
   // per-cycle attributes
   // ----------------------------------------------------------------
   logic [2:0] area_sel;
   logic [3:0] wait_pair;
   logic [1:0] wait_field;
   logic [15:0] wait_all;

   assign area_sel  = normal_mode_i ? 3'h0 : cycle_addr_i[AREA_SHIFT +: 3];
   assign wait_all  = {wait_count_upper_r, wait_count_lower_r};
   assign wait_pair = {area_sel, 1'b0};
   assign wait_field = wait_all[wait_pair +: 2];

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cycle_8bit_o     <= 1'b0;
         cycle_3state_o   <= 1'b0;
         cycle_wait_en_o  <= 1'b0;
         cycle_wait_cnt_o <= 2'h0;
      end else if (cycle_start_i) begin
         if (cycle_internal_i) begin
            cycle_8bit_o     <= 1'b0;
            cycle_3state_o   <= 1'b0;
            cycle_wait_en_o  <= 1'b0;
            cycle_wait_cnt_o <= 2'h0;
         end else begin
            cycle_8bit_o     <= area_bus_width_r[area_sel];
            cycle_3state_o   <= area_access_states_r[area_sel];
            cycle_wait_en_o  <= area_access_states_r[area_sel];
            cycle_wait_cnt_o <= area_access_states_r[area_sel] ? wait_field : 2'h0;
         end
      end
   end

   assign bus_control_upper_o = bus_control_upper_r;
   assign bus_control_lower_o = bus_control_lower_r;
endmodule : ext_bus_cfg_regs
`default_nettype wire

/* File: bench/ext_bus_cfg_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module ext_bus_cfg_chk (
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic        hw_standby_i,
   input wire logic [15:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        cycle_start_i,
   input wire logic        cycle_internal_i,
   input wire logic        cycle_8bit_o,
   input wire logic        cycle_3state_o,
   input wire logic        cycle_wait_en_o,
   input wire logic [1:0]  cycle_wait_cnt_o,
   input wire logic [7:0]  bus_control_upper_o,
   input wire logic [7:0]  bus_control_lower_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   property p_int; cycle_start_i && cycle_internal_i |=> !cycle_8bit_o && !cycle_3state_o;
   endproperty
   a_int: assert property (p_int) else $error("internal cycle not fixed");
   property p_wten; cycle_wait_en_o == cycle_3state_o; endproperty
   a_wten: assert property (p_wten) else $error("wait enable split");
   property p_cnt; !cycle_wait_en_o |-> cycle_wait_cnt_o == 2'h0; endproperty
   a_cnt: assert property (p_cnt) else $error("wait count without enable");
   property p_hold; !cycle_start_i |=> $stable({cycle_8bit_o, cycle_3state_o, cycle_wait_cnt_o});
   endproperty
   a_hold: assert property (p_hold) else $error("cycle outputs moved");
   property p_stby; hw_standby_i |=> bus_control_upper_o == 8'hd0 && bus_control_lower_o == 8'h3c;
   endproperty
   a_stby: assert property (p_stby) else $error("standby values");
   property p_unm; reg_rd_i && (reg_addr_i < 16'hfed0 || reg_addr_i > 16'hfed5) |=> reg_rdata_o == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read");
   property p_rdb; reg_rd_i && reg_addr_i == 16'hfed4 |=> reg_rdata_o == $past(bus_control_upper_o);
   endproperty
   a_rdb: assert property (p_rdb) else $error("read of upper control");
   property p_wrb; reg_wr_i && !hw_standby_i && reg_addr_i == 16'hfed5 |=>
      bus_control_lower_o == $past(reg_wdata_i); endproperty
   a_wrb: assert property (p_wrb) else $error("write of lower control");
   c_ext: cover property (cycle_start_i && !cycle_internal_i ##1 cycle_3state_o);
   c_stby: cover property (hw_standby_i ##1 !hw_standby_i);
   c_rd: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule // ext_bus_cfg_chk
bind ext_bus_cfg_regs ext_bus_cfg_chk chk (.*);
`default_nettype wire

/* File: bench/ext_bus_cfg_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module ext_bus_cfg_regs_tb;
   import ext_bus_cfg_pkg::*;
   logic        clk_i = 0, resetn_i = 0, hw_standby_i = 0, normal_mode_i = 0;
   logic        reg_wr_i = 0, reg_rd_i = 0, cycle_start_i = 0, cycle_internal_i = 0;
   logic        cycle_8bit_o, cycle_3state_o, cycle_wait_en_o;
   logic [1:0]  cycle_wait_cnt_o;
   logic [2:0]  op_mode_i = 3'h3;
   logic [15:0] reg_addr_i = 16'h0000;
   logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, bus_control_upper_o, bus_control_lower_o;
   logic [23:0] cycle_addr_i = 24'h00_0000;
   logic [7:0]  rv [6];
   logic [4:0]  e;
   int          fails = 0, comparisons = 0;
   wire logic [4:0] co = {cycle_8bit_o, cycle_3state_o, cycle_wait_en_o, cycle_wait_cnt_o};
   ext_bus_cfg_regs uut (
      .clk_i               (clk_i),
      .resetn_i            (resetn_i),
      .hw_standby_i        (hw_standby_i),
      .op_mode_i           (op_mode_i),
      .normal_mode_i       (normal_mode_i),
      .reg_addr_i          (reg_addr_i),
      .reg_wdata_i         (reg_wdata_i),
      .reg_wr_i            (reg_wr_i),
      .reg_rd_i            (reg_rd_i),
      .reg_rdata_o         (reg_rdata_o),
      .cycle_start_i       (cycle_start_i),
      .cycle_addr_i        (cycle_addr_i),
      .cycle_internal_i    (cycle_internal_i),
      .cycle_8bit_o        (cycle_8bit_o),
      .cycle_3state_o      (cycle_3state_o),
      .cycle_wait_en_o     (cycle_wait_en_o),
      .cycle_wait_cnt_o    (cycle_wait_cnt_o),
      .bus_control_upper_o (bus_control_upper_o),
      .bus_control_lower_o (bus_control_lower_o)
   );
   always #20 clk_i = ~clk_i;
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // read compares against d, write stores d
   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i <= w;
      reg_rd_i <= !w;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1 if (!w) chk("rdata", d, reg_rdata_o);
   endtask
   task automatic regs;
      for (int i = 0; i < 6; i++) bus(1'b0, OFS_WIDTH + 16'(i), rv[i]);
   endtask
   function automatic logic [4:0] ex(input logic [2:0] n);
      logic [15:0] wc;
      wc = {rv[2], rv[3]};
      return {rv[0][n], rv[1][n], rv[1][n], rv[1][n] ? wc[2*n+:2] : 2'h0};
   endfunction
   task automatic cyc(input logic [2:0] n, input logic in, input logic [4:0] x);
      @(posedge clk_i);
      cycle_start_i <= 1'b1;
      cycle_addr_i <= {n, 21'h00_0000};
      cycle_internal_i <= in;
      @(posedge clk_i);
      cycle_start_i <= 1'b0;
      #1 chk("cycle", {3'h0, x}, {3'h0, co});
   endtask
   task automatic tally_and_finish;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      rv = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      regs();
      bus(1'b0, 16'hfed6, 8'h00);
      bus(1'b0, 16'hfecf, 8'h00);
      bus(1'b1, 16'hfed6, 8'h77);
      rv = '{8'h5a, 8'ha5, 8'h1b, 8'he4, 8'h12, 8'h34};
      for (int i = 0; i < 6; i++) bus(1'b1, OFS_WIDTH + 16'(i), rv[i]);
      regs();
      cyc(3'h2, 1'b1, 5'h00);
      for (int n = 0; n < 8; n++) cyc(3'(n), 1'b0, ex(3'(n)));
      e = ex(3'h7);
      rv[1] = 8'h00;
      bus(1'b1, OFS_STATES, rv[1]);
      chk("held", {3'h0, e}, {3'h0, co});
      cyc(3'h7, 1'b0, ex(3'h7));
      normal_mode_i <= 1'b1;
      cyc(3'h3, 1'b0, ex(3'h0));
      op_mode_i <= MODE_FOUR;
      hw_standby_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      hw_standby_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rv = '{8'h00, 8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
      regs();
      tally_and_finish;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      tally_and_finish;
   end
endmodule // ext_bus_cfg_regs_tb
`default_nettype wire
